// file: rtl/sfe_params.svh
/*
 * Constants of the serial-port FIFO event block: register offsets,
 * field positions, reset values and FIFO geometry.
 * Assumes it is included by bare name from rtl/ and holds definitions only.
 */
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// register offsets, byte addresses on the register port
`define SFE_OFS_CTRL      6'h00
`define SFE_OFS_BITS      6'h04
`define SFE_OFS_DIV       6'h08
`define SFE_OFS_LEVEL     6'h0C
`define SFE_OFS_TXDATA    6'h10
`define SFE_OFS_RXDATA    6'h14
`define SFE_OFS_STATUS    6'h18
`define SFE_OFS_EVENTS    6'h1C
`define SFE_OFS_MASK      6'h20

// control register fields
`define SFE_CTRL_EN       0
`define SFE_CTRL_MASTER   1
`define SFE_CTRL_TXDMA    2
`define SFE_CTRL_RXDMA    3

// frame width fields: tx in [4:0], rx in [12:8]
`define SFE_BITS_TX_LSB   0
`define SFE_BITS_RX_LSB   8
`define SFE_BITS_RST      5'h08
`define SFE_BITS_MAX      5'h10

// level register fields: tx in [3:0], rx in [11:8]
`define SFE_LVL_TX_LSB    0
`define SFE_LVL_RX_LSB    8
`define SFE_LVL_RST       4'h0

// status register fields
`define SFE_ST_TXCNT_LSB  0
`define SFE_ST_RXCNT_LSB  8
`define SFE_ST_BUSY       16

// clock divider: system cycles per half serial period
`define SFE_DIV_RST       8'h04

// event bit positions, shared by events and mask registers
`define SFE_EV_DONE       0
`define SFE_EV_TX_NFULL   1
`define SFE_EV_TX_EMPTY   2
`define SFE_EV_TX_OVF     3
`define SFE_EV_TX_UNF     4
`define SFE_EV_TX_LVL     5
`define SFE_EV_BUS_ERR    6
`define SFE_EV_RX_NEMPTY  7
`define SFE_EV_RX_FULL    8
`define SFE_EV_RX_OVF     9
`define SFE_EV_RX_UNF     10
`define SFE_EV_RX_LVL     11
`define SFE_EV_PULSE_MASK 12'h659

// fifo geometry
`define SFE_FIFO_DEPTH    8
`define SFE_DATA_W        16

`endif

// file: rtl/sfe_pkg.sv
/*
 * Types of the serial-port FIFO event block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sfe_pkg;

    // master clock generator states, gray along idle-low-high
    typedef enum logic [1:0] {
        SFE_M_IDLE = 2'b00,
        SFE_M_LOW  = 2'b01,
        SFE_M_HIGH = 2'b11
    } sfe_mstate_type;

    // one bit for each event source
    typedef logic [11:0] sfe_event_type;

endpackage : sfe_pkg

// file: rtl/sfe_fifo.sv
/*
 * Small synchronous FIFO with registered head word and occupancy count.
 * Assumes push is never given while full and pop never while empty
 * (both are ignored if they are).
 */
`timescale 1ns/10ps
`default_nettype none

module sfe_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       push,
    input  wire logic [W-1:0]               wdata,
    input  wire logic                       pop,
    output logic      [W-1:0]               rdata,
    output logic      [$clog2(DEPTH):0]     count,
    output logic                            full,
    output logic                            empty
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];     // storage
    logic [AW-1:0] wr_ptr_r;        // next slot to fill
    logic [AW-1:0] rd_ptr_r;        // slot of head word
    logic [AW-1:0] rd_ptr_nxt;      // head slot after this cycle
    logic [AW:0]   count_r;         // occupancy
    logic          do_push;         // accepted push
    logic          do_pop;          // accepted pop

    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign full    = (count_r == (AW+1)'(DEPTH));
    assign empty   = (count_r == '0);
    assign count   = count_r;

    // pointer wrap works for any depth, not only powers of two
    assign rd_ptr_nxt = !do_pop ? rd_ptr_r :
                        (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;

    // write side
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= wdata;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // head register; bypass so a word pushed now is visible next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (do_push && (wr_ptr_r == rd_ptr_nxt)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[rd_ptr_nxt];
        end
    end

endmodule : sfe_fifo

`default_nettype wire

// file: rtl/sfe_core.sv
/*
 * Serial peripheral port with transmit and receive FIFOs, event flags,
 * sticky pulse events, one interrupt line and two DMA request lines.
 * Runs master (mode 0, msb first) or slave. Assumes a register master
 * on CLK and serial pins that are asynchronous to CLK; all pin inputs
 * pass a two-flop synchroniser.
 */
// How it works
// - tx dma request from level, fifo-only option
// - level sources follow live fifo state
// - master done as last bit of last element goes out
// - tx empty once last element enters shifter
// - done half a serial period before reception ends
// - tx not-full while room remains
// - write to full tx fifo: overflow pulse
// - shifter fetch from empty tx: underflow pulse
// - tx level active while count below level
// - slave deselect mid-frame flags bus error
// - rx not-empty and rx full follow fifo
// - receive into full rx fifo: overflow pulse
// - read of empty rx fifo: underflow pulse
// - rx level active while count above level
// - same levels drive events and dma
// - disable stops shifting at once
// - both fifos hold eight elements
// - frame width four to sixteen, per direction
`timescale 1ns/10ps
`default_nettype none

`include "sfe_params.svh"

module sfe_core #(
    parameter int DEPTH  = `SFE_FIFO_DEPTH,
    parameter int DATA_W = `SFE_DATA_W
) (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic [5:0]            REG_ADDR,
    input  wire logic [31:0]           REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic      [31:0]           REG_RDATA,
    input  wire logic                  SCLK_I,
    input  wire logic                  SS_N_I,
    input  wire logic                  MOSI_I,
    output logic                       MISO_O,
    output logic                       MISO_OE,
    output logic                       SCLK_O,
    output logic                       SS_N_O,
    output logic                       MOSI_O,
    input  wire logic                  MISO_I,
    output logic                       IRQ,
    output logic                       TRANSMIT_DMA_REQUEST,
    output logic                       RECEIVE_DMA_REQUEST,
    output sfe_pkg::sfe_event_type     EVENTS
);
    import sfe_pkg::*;

    localparam int CW = $clog2(DEPTH) + 1;

    // address match, used by the write decode and the rxdata read strobe
    function automatic logic sfe_hit(input logic [5:0] a, input logic [5:0] ofs);
        sfe_hit = (a == ofs);
    endfunction : sfe_hit

    // mask of the low n bits of a frame
    function automatic logic [15:0] sfe_bits_mask(input logic [4:0] n);
        sfe_bits_mask = 16'hFFFF >> (5'h10 - n);
    endfunction : sfe_bits_mask

    // configuration registers
    logic            en_r;          // block enable
    logic            master_r;      // master when high
    logic            txdma_r;       // tx buffer is fifo only, dma offered
    logic            rxdma_r;       // rx buffer is fifo only, dma offered
    logic [4:0]      tx_bits_r;     // tx frame width
    logic [4:0]      rx_bits_r;     // rx frame width
    logic [7:0]      div_r;         // half serial period in cycles
    logic [3:0]      tx_lvl_r;      // tx threshold
    logic [3:0]      rx_lvl_r;      // rx threshold
    sfe_event_type   mask_r;        // interrupt mask
    sfe_event_type   sticky_r;      // latched pulse events
    logic [31:0]     rdata_r;       // read data, one cycle after strobe

    // fifo signals
    logic            tx_push, tx_pop, tx_full, tx_empty;
    logic            rx_push, rx_pop, rx_full, rx_empty;
    logic [15:0]     tx_head, rx_head, rx_wdata;
    logic [CW-1:0]   tx_cnt, rx_cnt;

    // synchroniser, order {miso, mosi, ss_n, sclk}
    logic [3:0]      pin_m1_r;      // first stage, read only by second
    logic [3:0]      pin_s2_r;      // second stage, safe to use
    logic [3:0]      pin_s3_r;      // previous safe value for edges
    logic            s_sel, s_rise, s_fall, ss_fall, ss_rise;

    // shifting state
    sfe_mstate_type  mstate_r;      // master clock generator
    logic [7:0]      div_cnt_r;     // half period counter
    logic            m_tick, m_start, m_rise, m_fall;
    logic [15:0]     tx_sh_r;       // left-justified tx shifter
    logic [4:0]      tx_bit_r;      // tx bit index
    logic [15:0]     rx_sh_r;       // rx shifter, fills from lsb
    logic [4:0]      rx_bit_r;      // rx bit index
    logic            tx_last, rx_last, rise_ev, fall_ev, load_ev, din;
    logic            wr_txdata, rd_rxdata;
    sfe_event_type   pulse_ev, level_ev, ev_all;

    // register port decode
    assign wr_txdata = REG_WR && sfe_hit(REG_ADDR, `SFE_OFS_TXDATA);
    assign rd_rxdata = REG_RD && sfe_hit(REG_ADDR, `SFE_OFS_RXDATA);

    // both fifos, eight deep by default
    sfe_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
        .clk   (CLK),
        .rst   (RST),
        .push  (tx_push),
        .wdata (REG_WDATA[15:0]),
        .pop   (tx_pop),
        .rdata (tx_head),
        .count (tx_cnt),
        .full  (tx_full),
        .empty (tx_empty)
    );

    sfe_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
        .clk   (CLK),
        .rst   (RST),
        .push  (rx_push),
        .wdata (rx_wdata),
        .pop   (rx_pop),
        .rdata (rx_head),
        .count (rx_cnt),
        .full  (rx_full),
        .empty (rx_empty)
    );

    assign tx_push = wr_txdata && !tx_full;
    assign rx_pop  = rd_rxdata && !rx_empty;

    // configuration writes; software is expected to change them only while disabled
    always_ff @(posedge CLK) begin
        if (RST) begin
            en_r      <= 1'b0;
            master_r  <= 1'b0;
            txdma_r   <= 1'b0;
            rxdma_r   <= 1'b0;
            tx_bits_r <= `SFE_BITS_RST;
            rx_bits_r <= `SFE_BITS_RST;
            div_r     <= `SFE_DIV_RST;
            tx_lvl_r  <= `SFE_LVL_RST;
            rx_lvl_r  <= `SFE_LVL_RST;
            mask_r    <= '0;
        end else if (REG_WR) begin
            if (sfe_hit(REG_ADDR, `SFE_OFS_CTRL)) begin
                en_r     <= REG_WDATA[`SFE_CTRL_EN];
                master_r <= REG_WDATA[`SFE_CTRL_MASTER];
                txdma_r  <= REG_WDATA[`SFE_CTRL_TXDMA];
                rxdma_r  <= REG_WDATA[`SFE_CTRL_RXDMA];
            end
            if (sfe_hit(REG_ADDR, `SFE_OFS_BITS)) begin
                tx_bits_r <= REG_WDATA[`SFE_BITS_TX_LSB +: 5];
                rx_bits_r <= REG_WDATA[`SFE_BITS_RX_LSB +: 5];
            end
            if (sfe_hit(REG_ADDR, `SFE_OFS_DIV)) begin
                div_r <= REG_WDATA[7:0];
            end
            if (sfe_hit(REG_ADDR, `SFE_OFS_LEVEL)) begin
                tx_lvl_r <= REG_WDATA[`SFE_LVL_TX_LSB +: 4];
                rx_lvl_r <= REG_WDATA[`SFE_LVL_RX_LSB +: 4];
            end
            if (sfe_hit(REG_ADDR, `SFE_OFS_MASK)) begin
                mask_r <= REG_WDATA[11:0];
            end
        end
    end

    // pin synchroniser; idle levels are sclk low and select high
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_m1_r <= 4'h2;
            pin_s2_r <= 4'h2;
            pin_s3_r <= 4'h2;
        end else begin
            pin_m1_r <= {MISO_I, MOSI_I, SS_N_I, SCLK_I};
            pin_s2_r <= pin_m1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // slave-side edges, only from the settled stages
    assign s_sel   = en_r && !master_r && !pin_s2_r[1];
    assign s_rise  = s_sel && pin_s2_r[0] && !pin_s3_r[0];
    assign s_fall  = s_sel && !pin_s2_r[0] && pin_s3_r[0];
    assign ss_fall = en_r && !master_r && !pin_s2_r[1] && pin_s3_r[1];
    assign ss_rise = en_r && !master_r && pin_s2_r[1] && !pin_s3_r[1];

    // master clock timing; a zero divider acts as one
    assign m_tick  = (div_cnt_r + 8'h01 >= div_r);
    assign m_start = (mstate_r == SFE_M_IDLE) && !tx_empty;
    assign m_rise  = (mstate_r == SFE_M_LOW) && m_tick;
    assign m_fall  = (mstate_r == SFE_M_HIGH) && m_tick;

    assign tx_last = (tx_bit_r == tx_bits_r - 5'h01);
    assign rx_last = (rx_bit_r == rx_bits_r - 5'h01);

    // common shift events for both roles
    assign rise_ev = master_r ? m_rise : s_rise;
    assign fall_ev = master_r ? m_fall : s_fall;
    assign din     = master_r ? pin_s2_r[3] : pin_s2_r[2];
    // the master only fetches when data waits; the slave must fetch anyway
    assign load_ev = en_r && (master_r ? (m_start || (m_fall && tx_last && !tx_empty))
                                       : (ss_fall || (s_fall && tx_last)));
    assign tx_pop  = load_ev && !tx_empty;

    // master clock generator; disabling drops it to idle at once
    always_ff @(posedge CLK) begin
        if (RST || !en_r || !master_r) begin
            mstate_r  <= SFE_M_IDLE;
            div_cnt_r <= 8'h00;
        end else begin
            case (mstate_r)
                SFE_M_IDLE: begin
                    div_cnt_r <= 8'h00;
                    if (m_start) begin
                        mstate_r <= SFE_M_LOW;
                    end
                end
                SFE_M_LOW: begin
                    div_cnt_r <= m_tick ? 8'h00 : div_cnt_r + 8'h01;
                    if (m_tick) begin
                        mstate_r <= SFE_M_HIGH;
                    end
                end
                SFE_M_HIGH: begin
                    div_cnt_r <= m_tick ? 8'h00 : div_cnt_r + 8'h01;
                    if (m_tick) begin
                        // continuous frames while data waits, else release select
                        mstate_r <= (tx_last && tx_empty) ? SFE_M_IDLE : SFE_M_LOW;
                    end
                end
                default: begin
                    mstate_r <= SFE_M_IDLE;
                end
            endcase
        end
    end

    // transmit shifter; msb first, changes on the falling serial edge
    always_ff @(posedge CLK) begin
        if (RST || !en_r) begin
            tx_sh_r  <= 16'h0000;
            tx_bit_r <= 5'h00;
        end else if (load_ev) begin
            // an empty fifo in slave role sends zeros
            tx_sh_r  <= tx_empty ? 16'h0000
                                 : (tx_head & sfe_bits_mask(tx_bits_r)) << (5'h10 - tx_bits_r);
            tx_bit_r <= 5'h00;
        end else if (ss_rise) begin
            tx_bit_r <= 5'h00;
        end else if (fall_ev) begin
            tx_sh_r  <= {tx_sh_r[14:0], 1'b0};
            tx_bit_r <= tx_last ? 5'h00 : tx_bit_r + 5'h01;
        end
    end

    // receive shifter; samples on the rising serial edge
    always_ff @(posedge CLK) begin
        if (RST || !en_r) begin
            rx_sh_r  <= 16'h0000;
            rx_bit_r <= 5'h00;
        end else if (ss_rise) begin
            rx_bit_r <= 5'h00;
        end else if (rise_ev) begin
            rx_sh_r  <= {rx_sh_r[14:0], din};
            rx_bit_r <= rx_last ? 5'h00 : rx_bit_r + 5'h01;
        end
    end

    assign rx_wdata = {rx_sh_r[14:0], din} & sfe_bits_mask(rx_bits_r);
    assign rx_push  = en_r && rise_ev && rx_last && !rx_full;

    // pulse sources
    always_comb begin
        pulse_ev = '0;
        // done fires as the last bit goes out, half a period before its sample
        pulse_ev[`SFE_EV_DONE]    = en_r && m_fall && tx_empty &&
                                    (tx_bit_r == tx_bits_r - 5'h02);
        pulse_ev[`SFE_EV_TX_OVF]  = wr_txdata && tx_full;
        pulse_ev[`SFE_EV_TX_UNF]  = load_ev && tx_empty && !master_r;
        pulse_ev[`SFE_EV_BUS_ERR] = ss_rise && ((rx_bit_r != 5'h00) ||
                                                (tx_bit_r != 5'h00));
        pulse_ev[`SFE_EV_RX_OVF]  = en_r && rise_ev && rx_last && rx_full;
        pulse_ev[`SFE_EV_RX_UNF]  = rd_rxdata && rx_empty;
    end

    // level sources track the fifos directly
    always_comb begin
        level_ev = '0;
        level_ev[`SFE_EV_TX_NFULL]  = !tx_full;
        level_ev[`SFE_EV_TX_EMPTY]  = tx_empty;
        level_ev[`SFE_EV_TX_LVL]    = (tx_cnt < CW'(tx_lvl_r));
        level_ev[`SFE_EV_RX_NEMPTY] = !rx_empty;
        level_ev[`SFE_EV_RX_FULL]   = rx_full;
        level_ev[`SFE_EV_RX_LVL]    = (rx_cnt > CW'(rx_lvl_r));
    end

    // sticky pulse events; write one to clear, a new event beats the clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            sticky_r <= '0;
        end else if (REG_WR && sfe_hit(REG_ADDR, `SFE_OFS_EVENTS)) begin
            sticky_r <= (sticky_r & ~(REG_WDATA[11:0] & `SFE_EV_PULSE_MASK)) | pulse_ev;
        end else begin
            sticky_r <= sticky_r | pulse_ev;
        end
    end

    assign ev_all = sticky_r | level_ev;
    assign EVENTS = ev_all;
    assign IRQ    = |(ev_all & mask_r);

    // dma lines share the thresholds with the level events
    assign TRANSMIT_DMA_REQUEST = en_r && txdma_r && level_ev[`SFE_EV_TX_LVL];
    assign RECEIVE_DMA_REQUEST  = en_r && rxdma_r && level_ev[`SFE_EV_RX_LVL];

    // read mux; data stand in the cycle after the strobe only
    always_ff @(posedge CLK) begin
        if (RST || !REG_RD) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            case (REG_ADDR)
                `SFE_OFS_CTRL:   rdata_r <= {28'h0, rxdma_r, txdma_r, master_r, en_r};
                `SFE_OFS_BITS:   rdata_r <= {19'h0, rx_bits_r, 3'h0, tx_bits_r};
                `SFE_OFS_DIV:    rdata_r <= {24'h0, div_r};
                `SFE_OFS_LEVEL:  rdata_r <= {20'h0, rx_lvl_r, 4'h0, tx_lvl_r};
                `SFE_OFS_RXDATA: rdata_r <= {16'h0, rx_empty ? 16'h0000 : rx_head};
                `SFE_OFS_STATUS: begin
                    // busy lets software confirm the last frame was received
                    rdata_r <= 32'h0;
                    rdata_r[`SFE_ST_TXCNT_LSB +: CW] <= tx_cnt;
                    rdata_r[`SFE_ST_RXCNT_LSB +: CW] <= rx_cnt;
                    rdata_r[`SFE_ST_BUSY] <= (mstate_r != SFE_M_IDLE) || s_sel;
                end
                `SFE_OFS_EVENTS: rdata_r <= {20'h0, ev_all};
                `SFE_OFS_MASK:   rdata_r <= {20'h0, mask_r};
                default:         rdata_r <= 32'h0000_0000;   // unmapped and txdata
            endcase
        end
    end

    assign REG_RDATA = rdata_r;

    // pins: both data outputs come from the shifter flop
    assign MOSI_O  = tx_sh_r[15];
    assign MISO_O  = tx_sh_r[15];
    assign MISO_OE = s_sel;                          // drive only while selected
    assign SCLK_O  = (mstate_r == SFE_M_HIGH);
    assign SS_N_O  = (mstate_r == SFE_M_IDLE);

endmodule : sfe_core

`default_nettype wire

// file: test/sfe_core_chk.sv
/* Port checker for sfe_core: flags, dma lines, read port and select.
   Assumes a bind from the bench top and the shared params header. */
`timescale 1ns/10ps
`default_nettype none
`include "sfe_params.svh"
module sfe_core_chk (
    input wire logic                   CLK,
    input wire logic                   RST,
    input wire logic [5:0]             REG_ADDR,
    input wire logic [31:0]            REG_WDATA,
    input wire logic                   REG_WR,
    input wire logic                   REG_RD,
    input wire logic [31:0]            REG_RDATA,
    input wire logic                   SS_N_O,
    input wire logic                   IRQ,
    input wire logic                   TRANSMIT_DMA_REQUEST,
    input wire logic                   RECEIVE_DMA_REQUEST,
    input wire sfe_pkg::sfe_event_type EVENTS
);
    import sfe_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // decoded strobes
    wire logic tx_wr = REG_WR && REG_ADDR == `SFE_OFS_TXDATA;
    wire logic rx_rd = REG_RD && REG_ADDR == `SFE_OFS_RXDATA;
    wire logic ctl_off = REG_WR && REG_ADDR == `SFE_OFS_CTRL && !REG_WDATA[`SFE_CTRL_EN];
    sequence done_rise;
        $rose(EVENTS[`SFE_EV_DONE]);
    endsequence
    sequence unf_seen;
        REG_RDATA == 32'h0 && EVENTS[`SFE_EV_RX_UNF];
    endsequence
    reset_state_a: assert property (disable iff (1'b0) RST |=> EVENTS == 12'h006 && !IRQ
        && !TRANSMIT_DMA_REQUEST && !RECEIVE_DMA_REQUEST) else $error("bad reset state");
    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data outside read slot");
    rx_unf_a: assert property (rx_rd && !EVENTS[7] |=> unf_seen)
        else $error("empty read not flagged");
    tx_ovf_a: assert property (tx_wr && !EVENTS[1] |=> EVENTS[3])
        else $error("full write not flagged");
    stop_now_a: assert property (ctl_off |-> ##[1:2] SS_N_O && !TRANSMIT_DMA_REQUEST)
        else $error("disable did not stop");
    tx_dma_a: assert property (TRANSMIT_DMA_REQUEST |-> EVENTS[5])
        else $error("tx dma without level");
    rx_dma_a: assert property (RECEIVE_DMA_REQUEST |-> EVENTS[11])
        else $error("rx dma without level");
    full_empty_a: assert property (!EVENTS[1] |-> !EVENTS[2])
        else $error("tx full and empty");
    rx_full_a: assert property (EVENTS[8] |-> EVENTS[7])
        else $error("rx full but empty");
    done_order_a: assert property (done_rise |-> EVENTS[2])
        else $error("done before tx empty");
    irq_src_a: assert property (IRQ |-> |EVENTS)
        else $error("irq without source");
endmodule : sfe_core_chk
`default_nettype wire

// file: test/sfe_peer.sv
/* Serial peer on the master pins: a slave that echoes its input.
   Assumes mode 0 clock and active-low select from the block. */
`timescale 1ns/10ps
`default_nettype none
module sfe_peer (
    input  wire logic sclk,
    input  wire logic ss_n,
    input  wire logic mosi,
    output logic      miso
);
    logic last_r = 1'b0; // last bit sampled while selected
    // echo while selected; released line shows the inverse, never a hold
    always_comb miso = ss_n ? ~last_r : mosi;
    always @(posedge sclk) last_r <= mosi;
endmodule : sfe_peer
`default_nettype wire

// file: test/sfe_core_bench.sv
/* Bench for sfe_core: register tasks, echo peer on the master pins,
   slave pins driven here at a 48 ns link period. Assumes params header. */
`timescale 1ns/10ps
`default_nettype none
`include "sfe_params.svh"
module sfe_core_bench;
    import sfe_pkg::*;
    logic          CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
    logic [5:0]    REG_ADDR = 6'h00;
    logic [31:0]   REG_WDATA = 32'h0, REG_RDATA, d;
    logic          SCLK_I = 1'b0, SS_N_I = 1'b1, MOSI_I = 1'b0;
    logic          MISO_O, MISO_OE, SCLK_O, SS_N_O, MOSI_O, MISO_I, IRQ;
    logic          TRANSMIT_DMA_REQUEST, RECEIVE_DMA_REQUEST;
    sfe_event_type EVENTS;
    int            checks = 0, errors = 0, i;
    always #2 CLK = ~CLK;
    sfe_core dut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SCLK_I(SCLK_I),
        .SS_N_I(SS_N_I), .MOSI_I(MOSI_I), .MISO_O(MISO_O), .MISO_OE(MISO_OE),
        .SCLK_O(SCLK_O), .SS_N_O(SS_N_O), .MOSI_O(MOSI_O), .MISO_I(MISO_I), .IRQ(IRQ),
        .TRANSMIT_DMA_REQUEST(TRANSMIT_DMA_REQUEST),
        .RECEIVE_DMA_REQUEST(RECEIVE_DMA_REQUEST), .EVENTS(EVENTS));
    sfe_peer peer (.sclk(SCLK_O), .ss_n(SS_N_O), .mosi(MOSI_O), .miso(MISO_I));
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick
    // one-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask : wr
    // read strobe; data only stands the cycle after
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(posedge CLK);
        v = REG_RDATA;
    endtask : rd
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmpb(input logic got, input logic exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask : cmpb
    // slave frame of n link pulses; clock idles low outside it
    task automatic frame(input int n);
        SS_N_I <= 1'b0;
        tick(12);
        cmp({MISO_OE, MISO_O}, 32'h2);
        repeat (n) begin
            SCLK_I <= 1'b1;
            tick(6);
            SCLK_I <= 1'b0;
            MOSI_I <= ~MOSI_I;
            tick(6);
        end
        SS_N_I <= 1'b1;
        tick(12);
    endtask : frame
    task automatic results;
        $display("checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    // watchdog; whole run is under a thousand cycles
    initial begin
        tick(20000);
        errors++;
        results();
    end
    initial begin
        tick(16);
        RST <= 1'b0;
        tick(1);
        cmp({20'h0, EVENTS}, 32'h006);
        rd(6'h3C, d);
        cmp(d, 32'h0);
        $display("test reset done");
        wr(`SFE_OFS_LEVEL, 32'h103);
        wr(`SFE_OFS_CTRL, 32'h00D);
        for (i = 0; i < 9; i++) begin
            wr(`SFE_OFS_TXDATA, 32'hA0 + i);
            tick(2);
            cmp({TRANSMIT_DMA_REQUEST, EVENTS[1]}, {i < 2, i < 7});
        end
        cmpb(EVENTS[3], 1'b1);
        rd(`SFE_OFS_RXDATA, d);
        cmp({d[30:0], EVENTS[10]}, 32'h1);
        $display("test fill done");
        wr(`SFE_OFS_EVENTS, 32'h659);
        tick(1);
        cmpb(EVENTS[3], 1'b0);
        wr(`SFE_OFS_CTRL, 32'h00F);
        for (i = 0; i < 3000 && EVENTS[0] !== 1'b1; i++) tick(1);
        cmp({EVENTS[2], SS_N_O, EVENTS[0]}, 32'h5);
        rd(`SFE_OFS_STATUS, d);
        cmp(d, 32'h10700);
        for (i = 0; i < 200 && SS_N_O !== 1'b1; i++) tick(1);
        tick(2);
        rd(`SFE_OFS_STATUS, d);
        cmp(d, 32'h800);
        cmp({EVENTS[8], RECEIVE_DMA_REQUEST}, 32'h3);
        wr(`SFE_OFS_TXDATA, 32'h55);
        for (i = 0; i < 50 && SS_N_O !== 1'b0; i++) tick(1);
        for (i = 0; i < 200 && SS_N_O !== 1'b1; i++) tick(1);
        tick(2);
        cmpb(EVENTS[9], 1'b1);
        for (i = 0; i < 8; i++) begin
            rd(`SFE_OFS_RXDATA, d);
            cmp(d, 32'hA0 + i);
        end
        cmpb(EVENTS[7], 1'b0);
        $display("test master done");
        wr(`SFE_OFS_TXDATA, 32'h3C);
        tick(20);
        wr(`SFE_OFS_CTRL, 32'h0);
        tick(2);
        cmpb(SS_N_O, 1'b1);
        wr(`SFE_OFS_EVENTS, 32'h659);
        wr(`SFE_OFS_CTRL, 32'h001);
        frame(3);
        cmp({EVENTS[6], EVENTS[4]}, 32'h3);
        wr(`SFE_OFS_MASK, 32'h040);
        tick(2);
        cmpb(IRQ, 1'b1);
        wr(`SFE_OFS_EVENTS, 32'h040);
        tick(2);
        cmpb(IRQ, 1'b0);
        // four-bit slave frame: bits 1,0,1,0 land as one word, no bus error
        wr(`SFE_OFS_CTRL, 32'h0);
        wr(`SFE_OFS_BITS, 32'h404);
        wr(`SFE_OFS_CTRL, 32'h001);
        frame(4);
        rd(`SFE_OFS_RXDATA, d);
        cmp({d[30:0], EVENTS[6]}, 32'h14);
        $display("test slave done");
        results();
    end
endmodule : sfe_core_bench
bind sfe_core sfe_core_chk chk (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SS_N_O(SS_N_O), .IRQ(IRQ), .TRANSMIT_DMA_REQUEST(TRANSMIT_DMA_REQUEST),
    .RECEIVE_DMA_REQUEST(RECEIVE_DMA_REQUEST), .EVENTS(EVENTS));
`default_nettype wire
